// file: ssm_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// Summary of operation
// - Mode zero disables all checks and faults
// - Mode two reports any timed-out enabled check
// - Track checked always, marks with expansion module
// - Armed only with release and start
// - Fault only after uninterrupted full timeout
// - Persisting faulty signal while released trips drive
// - Zero timeout disables only that check
// - Timeouts 0 to 65000 ms, default 1000
// - Zero speed with nonzero controller output gives sensor fault
// - Bad quadrature sequence gives sensor fault
// - Sign mismatch gives direction fault
// - Quarter turn toward reference clears direction check
// - Zero speed at current limit gives blocked
module ssm_monitor
   import ssm_pkg::*;
#(
   parameter int MS_CYC = MS_CYCLES,
   parameter logic [15:0] QUARTER_COUNTS = QUARTER_DEF
) (
   // Clock and reset
   input wire logic CLK_I,
   input wire logic RESET_I,
   // Register port
   input wire logic [3:0] ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [31:0] RDATA_O,
   // Encoder tracks and feedback expansion module
   input wire logic TRACK_A_I,
   input wire logic TRACK_B_I,
   input wire logic EXP_PRESENT_I,
   input wire logic MARK_FAULT_I,
   // Drive state
   input wire logic signed [15:0] SPEED_REF_I,
   input wire logic signed [15:0] SPEED_ACT_I,
   input wire logic signed [15:0] CTRL_OUT_I,
   input wire logic CURR_LIMIT_I,
   input wire logic RELEASE_I,
   input wire logic START_I,
   input wire logic FAULT_ACK_I,
   // Fault outputs
   output logic TRIP_O,
   output logic [15:0] FAULT_CODE_O,
   output logic IRQ_O
);

   // =======================================================
   // Register file
   logic [1:0] mode_r, mode_nxt;
   logic [15:0] tmo_r [4];
   logic [15:0] tmo_nxt [4];
   logic [3:0] stat_r, stat_nxt;
   logic [3:0] en_r, en_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [3:0] trip_ev;
   logic [15:0] fcode_r, fcode_nxt;
   logic trip_r, trip_nxt;
   logic irq_r, irq_nxt;

   function automatic logic [15:0] clip_tmo(input logic [31:0] v);
      if (v[31:16] != 16'h0000 || v[15:0] > TMO_MAX_MS) begin
         clip_tmo = TMO_MAX_MS;
      end else begin
         clip_tmo = v[15:0];
      end
   endfunction

   always_comb begin
      mode_nxt = mode_r;
      en_nxt = en_r;
      rdata_nxt = 32'h0000_0000;
      for (int i = 0; i < 4; i++) begin
         tmo_nxt[i] = tmo_r[i];
      end
      stat_nxt = stat_r;
      if (WR_I) begin
         case (ADDR_I)
            REG_CTRL: mode_nxt = WDATA_I[1:0];
            REG_TMO_SIG: tmo_nxt[0] = clip_tmo(WDATA_I);
            REG_TMO_TRK: tmo_nxt[1] = clip_tmo(WDATA_I);
            REG_TMO_DIR: tmo_nxt[2] = clip_tmo(WDATA_I);
            REG_TMO_BLK: tmo_nxt[3] = clip_tmo(WDATA_I);
            REG_CLEAR: stat_nxt = stat_r & ~WDATA_I[3:0];
            REG_ENABLE: en_nxt = WDATA_I[3:0];
            default: ;
         endcase
      end
      stat_nxt = stat_nxt | trip_ev;
      if (RD_I) begin
         case (ADDR_I)
            REG_CTRL: rdata_nxt = {30'h0, mode_r};
            REG_TMO_SIG: rdata_nxt = {16'h0, tmo_r[0]};
            REG_TMO_TRK: rdata_nxt = {16'h0, tmo_r[1]};
            REG_TMO_DIR: rdata_nxt = {16'h0, tmo_r[2]};
            REG_TMO_BLK: rdata_nxt = {16'h0, tmo_r[3]};
            REG_STATUS: rdata_nxt = {28'h0, stat_r};
            REG_ENABLE: rdata_nxt = {28'h0, en_r};
            REG_FCODE: rdata_nxt = {15'h0, trip_r, fcode_r};
            default: rdata_nxt = 32'h0000_0000;
         endcase
      end
      irq_nxt = |(stat_nxt & en_nxt);
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         mode_r <= MODE_ERROR;
         en_r <= 4'h0;
         stat_r <= 4'h0;
         rdata_r <= 32'h0000_0000;
         irq_r <= 1'b0;
         for (int i = 0; i < 4; i++) begin
            tmo_r[i] <= TMO_DEF_MS;
         end
      end else begin
         mode_r <= mode_nxt;
         en_r <= en_nxt;
         stat_r <= stat_nxt;
         rdata_r <= rdata_nxt;
         irq_r <= irq_nxt;
         for (int i = 0; i < 4; i++) begin
            tmo_r[i] <= tmo_nxt[i];
         end
      end
   end

   // =======================================================
   // Quadrature sequence and position tracking
   logic [1:0] ab_r, ab_nxt;
   logic seq_bad;
   logic step_fwd, step_rev;
   logic [15:0] pos_r, pos_nxt;
   logic dir_reset;
   logic armed;
   logic [3:0] cond;

   always_comb begin
      ab_nxt = {TRACK_A_I, TRACK_B_I};
      step_fwd = (ab_r ^ ab_nxt) != 2'b00 && (ab_r[1] ^ ab_nxt[0]);
      step_rev = (ab_r ^ ab_nxt) != 2'b00 && !(ab_r[1] ^ ab_nxt[0]);
      seq_bad = (ab_r ^ ab_nxt) == 2'b11;
      pos_nxt = pos_r;
      dir_reset = 1'b0;
      if (!cond[ST_DIR]) begin
         pos_nxt = 16'h0000;
      end else if ((step_fwd && !SPEED_REF_I[15]) ||
                   (step_rev && SPEED_REF_I[15])) begin
         pos_nxt = pos_r + 16'h0001;
      end
      if (pos_nxt >= QUARTER_COUNTS) begin
         dir_reset = 1'b1;
         pos_nxt = 16'h0000;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         ab_r <= 2'b00;
         pos_r <= 16'h0000;
      end else begin
         ab_r <= ab_nxt;
         pos_r <= pos_nxt;
      end
   end

   // =======================================================
   // Fault conditions
   always_comb begin
      armed = RELEASE_I && START_I && mode_r == MODE_ERROR;
      cond[ST_SIG] = SPEED_ACT_I == 16'sh0000 &&
                     CTRL_OUT_I != 16'sh0000;
      cond[ST_TRK] = seq_bad || (EXP_PRESENT_I && MARK_FAULT_I);
      cond[ST_DIR] = SPEED_REF_I != 16'sh0000 &&
                     SPEED_ACT_I != 16'sh0000 &&
                     (SPEED_REF_I[15] != SPEED_ACT_I[15]);
      cond[ST_BLK] = SPEED_ACT_I == 16'sh0000 && CURR_LIMIT_I;
   end

   // =======================================================
   // Millisecond timers, one per check
   logic [31:0] pre_r [4];
   logic [31:0] pre_nxt [4];
   logic [15:0] ms_r [4];
   logic [15:0] ms_nxt [4];
   logic [3:0] track_hold_r, track_hold_nxt;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_chk
         logic live;
         always_comb begin
            live = g == ST_TRK ? (cond[g] || track_hold_r[g]) : cond[g];
            pre_nxt[g] = 32'h0;
            ms_nxt[g] = 16'h0;
            trip_ev[g] = 1'b0;
            if (armed && tmo_r[g] != 16'h0 && live &&
                !(g == ST_DIR && dir_reset)) begin
               pre_nxt[g] = pre_r[g] + 32'h1;
               ms_nxt[g] = ms_r[g];
               if (pre_r[g] == 32'(MS_CYC - 1)) begin
                  pre_nxt[g] = 32'h0;
                  ms_nxt[g] = ms_r[g] + 16'h1;
               end
               if (ms_nxt[g] >= tmo_r[g]) begin
                  trip_ev[g] = 1'b1;
                  ms_nxt[g] = tmo_r[g];
               end
            end
         end
         always_ff @(posedge CLK_I) begin
            if (RESET_I) begin
               pre_r[g] <= 32'h0;
               ms_r[g] <= 16'h0;
            end else begin
               pre_r[g] <= pre_nxt[g];
               ms_r[g] <= ms_nxt[g];
            end
         end
      end
   endgenerate

   // Track error stays pending until a clean valid step is seen
   always_comb begin
      track_hold_nxt = 4'h0;
      track_hold_nxt[ST_TRK] = seq_bad ||
         (track_hold_r[ST_TRK] && !(step_fwd || step_rev));
   end

   // =======================================================
   // Latched switch-off and fault code
   always_comb begin
      trip_nxt = trip_r;
      fcode_nxt = fcode_r;
      if (FAULT_ACK_I) begin
         trip_nxt = 1'b0;
         fcode_nxt = FC_NONE;
      end
      if ((!trip_r || FAULT_ACK_I) && |trip_ev) begin
         trip_nxt = 1'b1;
         if (trip_ev[ST_SIG] || trip_ev[ST_TRK]) begin
            fcode_nxt = FC_SENSOR;
         end else if (trip_ev[ST_DIR]) begin
            fcode_nxt = FC_DIRECTION;
         end else begin
            fcode_nxt = FC_BLOCKED;
         end
      end
   end

   always_ff @(posedge CLK_I) begin
      if (RESET_I) begin
         trip_r <= 1'b0;
         fcode_r <= FC_NONE;
         track_hold_r <= 4'h0;
      end else begin
         trip_r <= trip_nxt;
         fcode_r <= fcode_nxt;
         track_hold_r <= track_hold_nxt;
      end
   end

   assign RDATA_O = rdata_r;
   assign TRIP_O = trip_r;
   assign FAULT_CODE_O = fcode_r;
   assign IRQ_O = irq_r;

   // =======================================================
   // Assertions
   a_mode_off_quiet: assert property (
      @(posedge CLK_I) disable iff (RESET_I)
      mode_r == MODE_OFF && !trip_r |=> !trip_r)
      else $error("trip while monitoring off");
   a_disarm_clears: assert property (
      @(posedge CLK_I) disable iff (RESET_I)
      !(RELEASE_I && START_I) |=> ms_r[0] == 16'h0 && pre_r[0] == 32'h0)
      else $error("timer runs while not armed");
   a_zero_tmo_off: assert property (
      @(posedge CLK_I) disable iff (RESET_I)
      tmo_r[ST_BLK] == 16'h0 |-> !trip_ev[ST_BLK])
      else $error("disabled check fired");
   a_trip_latched: assert property (
      @(posedge CLK_I) disable iff (RESET_I)
      trip_r && !FAULT_ACK_I |=> trip_r && fcode_r == $past(fcode_r))
      else $error("fault lost without acknowledge");
   a_event_trips: assert property (
      @(posedge CLK_I) disable iff (RESET_I)
      |trip_ev && (!trip_r || FAULT_ACK_I) |=> trip_r)
      else $error("event did not trip");
   a_code_dir: assert property (
      @(posedge CLK_I) disable iff (RESET_I)
      !trip_r && trip_ev == 4'b0100 |=> fcode_r == FC_DIRECTION)
      else $error("wrong direction code");
   a_code_blk: assert property (
      @(posedge CLK_I) disable iff (RESET_I)
      !trip_r && trip_ev == 4'b1000 |=> fcode_r == FC_BLOCKED)
      else $error("wrong blocked code");
   a_ms_restart: assert property (
      @(posedge CLK_I) disable iff (RESET_I)
      !cond[ST_SIG] |=> ms_r[ST_SIG] == 16'h0)
      else $error("timer not restarted");
   a_tmo_range: assert property (
      @(posedge CLK_I) disable iff (RESET_I)
      tmo_r[1] <= TMO_MAX_MS)
      else $error("timeout beyond range");
endmodule

// file: ssm_pkg.sv
// ==========================================================
// Speed sensor monitor constants
package ssm_pkg;
   // Operating clock and timebase
   localparam int CLK_MHZ = 250;
   localparam int MS_NS = 1000000;
   localparam int CLK_NS = 4;
   localparam int MS_CYCLES = MS_NS / CLK_NS;
   // Monitoring mode encodings
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_ERROR = 2'h2;
   // Timeout range and reset value in milliseconds
   localparam logic [15:0] TMO_MAX_MS = 16'hfde8;
   localparam logic [15:0] TMO_DEF_MS = 16'h03e8;
   // Register indices
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_TMO_SIG = 4'h1;
   localparam logic [3:0] REG_TMO_TRK = 4'h2;
   localparam logic [3:0] REG_TMO_DIR = 4'h3;
   localparam logic [3:0] REG_TMO_BLK = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h5;
   localparam logic [3:0] REG_CLEAR = 4'h6;
   localparam logic [3:0] REG_ENABLE = 4'h7;
   localparam logic [3:0] REG_FCODE = 4'h8;
   // Status bit positions
   localparam int ST_SIG = 0;
   localparam int ST_TRK = 1;
   localparam int ST_DIR = 2;
   localparam int ST_BLK = 3;
   // Fault codes, decimal value of the displayed number
   localparam logic [15:0] FC_SENSOR = 16'h0596;
   localparam logic [15:0] FC_DIRECTION = 16'h0598;
   localparam logic [15:0] FC_BLOCKED = 16'h059e;
   localparam logic [15:0] FC_NONE = 16'h0000;
   // Quarter revolution in quadrature counts
   localparam logic [15:0] QUARTER_DEF = 16'h0100;
endpackage

// file: ssm_quad_model.sv
`timescale 1ns/1ps
// ==========================================================
// Incremental encoder with two quadrature tracks
module ssm_quad_model (
   // Clock
   input wire logic clk_i,
   // Motion commands
   input wire logic step_i,
   input wire logic dir_i,
   input wire logic glitch_i,
   // Tracks
   output logic a_o,
   output logic b_o
);
   logic [1:0] ph_r = 2'h0;
   always_ff @(posedge clk_i) begin
      if (glitch_i) begin
         ph_r <= ph_r + 2'h2; // Both tracks flip at once
      end else if (step_i) begin
         ph_r <= dir_i ? ph_r + 2'h1 : ph_r - 2'h1; // One edge
      end
   end
   assign a_o = ph_r[1];
   assign b_o = ph_r[1] ^ ph_r[0];
endmodule

// file: test_ssm_monitor.sv
`timescale 1ns/1ps
// ==========================================================
// Self-checking bench for the speed sensor monitor
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
   failures++; $display("Error %s expected %h seen %h", n, e, s); end end
module test_ssm_monitor;
   import ssm_pkg::*;
   localparam int MSC = 4;
   logic CLK_I = 1'b0, RESET_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0;
   logic [3:0] ADDR_I = 4'h0;
   logic [31:0] WDATA_I = 32'h0, e_v;
   logic signed [15:0] SPEED_REF_I = 16'h0, SPEED_ACT_I = 16'h0;
   logic signed [15:0] CTRL_OUT_I = 16'h0, ctl, r;
   logic CURR_LIMIT_I = 1'b0, RELEASE_I = 1'b1, START_I = 1'b1;
   logic FAULT_ACK_I = 1'b0, EXP_PRESENT_I = 1'b0, MARK_FAULT_I = 1'b0;
   logic step = 1'b0, glitch = 1'b0, rd_d = 1'b0;
   logic TRACK_A_I, TRACK_B_I, TRIP_O, IRQ_O;
   logic [31:0] RDATA_O;
   logic [15:0] FAULT_CODE_O;
   logic [31:0] exp_q[$];
   string name_q[$], n_v;
   int failures = 0, total_checks = 0, seed = 33393;
   ssm_monitor #(.MS_CYC(MSC), .QUARTER_COUNTS(16'h0004))
      u_ssm_monitor (.CLK_I(CLK_I),
      .RESET_I(RESET_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
      .RD_I(RD_I), .RDATA_O(RDATA_O), .TRACK_A_I(TRACK_A_I),
      .TRACK_B_I(TRACK_B_I), .EXP_PRESENT_I(EXP_PRESENT_I),
      .MARK_FAULT_I(MARK_FAULT_I), .SPEED_REF_I(SPEED_REF_I),
      .SPEED_ACT_I(SPEED_ACT_I), .CTRL_OUT_I(CTRL_OUT_I),
      .CURR_LIMIT_I(CURR_LIMIT_I), .RELEASE_I(RELEASE_I),
      .START_I(START_I), .FAULT_ACK_I(FAULT_ACK_I), .TRIP_O(TRIP_O),
      .FAULT_CODE_O(FAULT_CODE_O), .IRQ_O(IRQ_O));
   ssm_quad_model u_ssm_quad_model (.clk_i(CLK_I), .step_i(step),
      .dir_i(1'b1), .glitch_i(glitch), .a_o(TRACK_A_I), .b_o(TRACK_B_I));
   initial begin
      forever #2 CLK_I = ~CLK_I;
   end
   // ==========================================================
   // Read data watcher
   always @(posedge CLK_I) rd_d <= RD_I;
   always @(negedge CLK_I) begin
      if (rd_d === 1'b1 && exp_q.size() > 0) begin
         e_v = exp_q.pop_front();
         n_v = name_q.pop_front();
         `CHK(n_v, e_v, RDATA_O)
      end
   end
   // ==========================================================
   // Tasks
   task automatic bus(input logic w, input logic [3:0] a,
      input logic [31:0] d, input string n);
      @(posedge CLK_I);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= w;
      RD_I <= !w;
      if (!w) begin
         exp_q.push_back(d);
         name_q.push_back(n);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) begin
         @(posedge CLK_I);
         WR_I <= 1'b0;
         RD_I <= 1'b0;
      end
   endtask
   task automatic drv(input logic [15:0] rf, a, o, input logic cl);
      @(posedge CLK_I);
      SPEED_REF_I <= rf;
      SPEED_ACT_I <= a;
      CTRL_OUT_I <= o;
      CURR_LIMIT_I <= cl;
      WR_I <= 1'b0;
      RD_I <= 1'b0;
   endtask
   task automatic trip_chk(input logic [15:0] code, input logic hit);
      idle(3 * MSC - 2);
      #1;
      `CHK("early trip", 1'b0, TRIP_O)
      for (int i = 0; i < 12 && TRIP_O !== 1'b1; i++) begin
         idle(1);
         #1;
      end
      `CHK("trip", hit, TRIP_O)
      `CHK("code", hit ? code : FC_NONE, FAULT_CODE_O)
   endtask
   task automatic clr;
      drv(16'h0, 16'h0, 16'h0, 1'b0);
      FAULT_ACK_I <= 1'b1;
      idle(1);
      FAULT_ACK_I <= 1'b0;
      bus(1, REG_CLEAR, 32'hf, "");
      idle(2);
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge CLK_I);
      failures++;
      tally_and_finish();
   end
   // ==========================================================
   // Main sequence
   initial begin
      ctl = 16'($random(seed)) | 16'h0001;
      r = (16'($random(seed)) & 16'h3fff) | 16'h0001;
      repeat (10) @(posedge CLK_I);
      RESET_I <= 1'b0;
      bus(0, REG_CTRL, {30'h0, MODE_ERROR}, "ctrl");
      bus(0, REG_TMO_BLK, {16'h0, TMO_DEF_MS}, "tmo");
      bus(0, REG_ENABLE, 32'h0, "enable");
      bus(1, REG_TMO_SIG, 32'h00011170, "");
      bus(0, REG_TMO_SIG, {16'h0, TMO_MAX_MS}, "clip");
      bus(0, 4'hc, 32'h0, "unmapped");
      for (int i = 1; i <= 4; i++) bus(1, 4'(i), 32'h3, "");
      bus(1, REG_ENABLE, 32'hf, "");
      idle(1);
      drv(16'h0, 16'h0, ctl, 1'b0);
      idle(8);
      drv(16'h0, 16'h5, ctl, 1'b0);
      drv(16'h0, 16'h0, ctl, 1'b0);
      trip_chk(FC_SENSOR, 1'b1);
      bus(0, REG_STATUS, 32'h1, "status");
      bus(0, REG_FCODE, {15'h0, 1'b1, FC_SENSOR}, "fcode");
      idle(1);
      #1;
      `CHK("irq on", 1'b1, IRQ_O)
      bus(1, REG_ENABLE, 32'h0, "");
      idle(2);
      #1;
      `CHK("irq masked", 1'b0, IRQ_O)
      bus(1, REG_ENABLE, 32'hf, "");
      clr();
      bus(0, REG_STATUS, 32'h0, "status clr");
      bus(0, REG_FCODE, 32'h0, "fcode clr");
      bus(1, REG_CTRL, 32'h0, "");
      drv(16'h0, 16'h0, ctl, 1'b0);
      trip_chk(FC_SENSOR, 1'b0);
      bus(1, REG_CTRL, {30'h0, MODE_ERROR}, "");
      RELEASE_I <= 1'b0;
      drv(16'h0, 16'h0, ctl, 1'b0);
      trip_chk(FC_SENSOR, 1'b0);
      clr();
      RELEASE_I <= 1'b1;
      bus(1, REG_TMO_SIG, 32'h0, "");
      drv(16'h0, 16'h0, ctl, 1'b1);
      trip_chk(FC_BLOCKED, 1'b1);
      clr();
      bus(1, REG_TMO_SIG, 32'h3, "");
      drv(r, -r, ctl, 1'b0);
      trip_chk(FC_DIRECTION, 1'b1);
      clr();
      drv(r, -r, ctl, 1'b0);
      step <= 1'b1;
      trip_chk(FC_DIRECTION, 1'b0);
      idle(1);
      step <= 1'b0;
      clr();
      drv(r, r, ctl, 1'b0);
      glitch <= 1'b1;
      idle(1);
      glitch <= 1'b0;
      trip_chk(FC_SENSOR, 1'b1);
      bus(0, REG_STATUS, 32'h2, "track status");
      step <= 1'b1;
      idle(1);
      step <= 1'b0;
      clr();
      MARK_FAULT_I <= 1'b1;
      drv(r, r, ctl, 1'b0);
      trip_chk(FC_SENSOR, 1'b0);
      @(posedge CLK_I);
      EXP_PRESENT_I <= 1'b1;
      trip_chk(FC_SENSOR, 1'b1);
      idle(4);
      tally_and_finish();
   end
endmodule
